// file: rtl/pes_pkg.sv
package pes_pkg;

    // ------------------------------------------------------------------
    // Register map, word indices; byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [5:0]  IDX_TEST       = 6'h11;
    localparam logic [5:0]  IDX_STAT       = 6'h12;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int unsigned POS_POLARITY   = 3;
    localparam int unsigned POS_TEST       = 2;
    localparam int unsigned POS_STAT_LO    = 8;
    localparam int unsigned POS_EN_LO      = 0;
    localparam int unsigned EVT_N          = 8;

    // Event order follows the status bits, lowest first.
    localparam int unsigned EV_RX_ERR      = 0;
    localparam int unsigned EV_FALSE_CAR   = 1;
    localparam int unsigned EV_TRAINING    = 2;
    localparam int unsigned EV_ESD         = 3;
    localparam int unsigned EV_WAKE        = 4;
    localparam int unsigned EV_LINK        = 5;
    localparam int unsigned EV_ENERGY      = 6;
    localparam int unsigned EV_QUALITY     = 7;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_STATUS     = 8'h00;
    localparam logic [7:0]  RST_ENABLE     = 8'h00;
    localparam logic        RST_POLARITY   = 1'b1;
    localparam logic        RST_TEST       = 1'b0;
    localparam logic [15:0] RSV_TEST_READ  = 16'h0103;

    // ------------------------------------------------------------------
    // Widths and thresholds.
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W_DEF     = 8;
    localparam int unsigned FC_W_DEF       = 8;
    localparam int unsigned RE_W_DEF       = 16;
    localparam logic [7:0]  FC_HALF        = 8'h7F;

endpackage

// file: rtl/pes_evt_detect.sv
`timescale 1ns/100ps
`default_nettype none

module pes_evt_detect #(
    parameter int unsigned FC_W = pes_pkg::FC_W_DEF,
    parameter int unsigned RE_W = pes_pkg::RE_W_DEF
) (
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              link_quality_i,
    input  wire logic              link_up_i,
    input  wire logic              energy_detect_i,
    input  wire logic              wake_frame_i,
    input  wire logic              esd_event_i,
    input  wire logic              leader_follower_done_i,
    input  wire logic [FC_W-1:0]   false_carrier_counter_i,
    input  wire logic [RE_W-1:0]   receive_error_counter_i,
    output logic      [7:0]        evt_o
);

    // ------------------------------------------------------------------
    // Threshold helpers.
    // ------------------------------------------------------------------
    localparam logic [FC_W-1:0] FC_HALF_W = FC_W'(pes_pkg::FC_HALF);
    localparam logic [RE_W-1:0] RE_HALF_W = {1'b0, {(RE_W-1){1'b1}}};

    function automatic logic crossed(input logic now_above,
                                     input logic was_above);
        crossed = now_above & ~was_above;
    endfunction

    logic       primed_ff;
    logic       quality_ff;
    logic       energy_ff;
    logic       link_ff;
    logic       wake_ff;
    logic       esd_ff;
    logic       train_ff;
    logic       fc_above_ff;
    logic       re_above_ff;
    logic       fc_above;
    logic       re_above;

    assign fc_above = false_carrier_counter_i > FC_HALF_W;
    assign re_above = receive_error_counter_i > RE_HALF_W;

    // ------------------------------------------------------------------
    // History of every source; no event is taken before one sample.
    // ------------------------------------------------------------------
    // Without the primed flag a source already high at reset release
    // would be mistaken for a change.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            primed_ff   <= 1'b0;
            quality_ff  <= 1'b0;
            energy_ff   <= 1'b0;
            link_ff     <= 1'b0;
            wake_ff     <= 1'b0;
            esd_ff      <= 1'b0;
            train_ff    <= 1'b0;
            fc_above_ff <= 1'b0;
            re_above_ff <= 1'b0;
        end else begin
            primed_ff   <= 1'b1;
            quality_ff  <= link_quality_i;
            energy_ff   <= energy_detect_i;
            link_ff     <= link_up_i;
            wake_ff     <= wake_frame_i;
            esd_ff      <= esd_event_i;
            train_ff    <= leader_follower_done_i;
            fc_above_ff <= fc_above;
            re_above_ff <= re_above;
        end
    end

    always_comb begin
        evt_o = '0;
        if (primed_ff) begin
            evt_o[pes_pkg::EV_QUALITY]   = (link_quality_i != quality_ff)
                                           & link_up_i;
            evt_o[pes_pkg::EV_ENERGY]    = energy_detect_i
                                           != energy_ff;
            evt_o[pes_pkg::EV_LINK]      = link_up_i != link_ff;
            evt_o[pes_pkg::EV_WAKE]      = crossed(wake_frame_i,
                                                   wake_ff);
            evt_o[pes_pkg::EV_ESD]       = crossed(esd_event_i,
                                                   esd_ff);
            evt_o[pes_pkg::EV_TRAINING]  = crossed(leader_follower_done_i,
                                                   train_ff);
            evt_o[pes_pkg::EV_FALSE_CAR] = crossed(fc_above,
                                                   fc_above_ff);
            evt_o[pes_pkg::EV_RX_ERR]    = crossed(re_above,
                                                   re_above_ff);
        end
    end

    chk_fc_half_cross: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (primed_ff && fc_above_ff == 1'b0
         && false_carrier_counter_i > FC_HALF_W)
        |-> evt_o[pes_pkg::EV_FALSE_CAR])
        else $error("False carrier crossing gave no event.");

endmodule

`default_nettype wire

// file: rtl/pes_event_status_one.sv
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Summary of operation
// - Link quality change while up sets bit 15.
// - Energy detect change sets bit 14.
// - Link status change sets bit 13.
// - Wake frame detection sets bit 12.
// - Discharge monitor event sets bit 11.
// - Leader/follower training done sets bit 10.
// - False carrier counter past half sets 9.
// - Receive error counter past half sets 8.
// - Enables 7..5 read-write, reset zero.
// - Enables 4..2 read-write, reset zero.
// - Enables 1..0 read-write, reset zero.
// - Polarity bit picks interrupt pin idle level.
// - Test bit forces interrupt while set.
// - False carrier event past count 0x7F.
// ----------------------------------------------------------------------

module pes_event_status_one #(
    parameter int unsigned ADDR_W = pes_pkg::ADDR_W_DEF,
    parameter int unsigned FC_W   = pes_pkg::FC_W_DEF,
    parameter int unsigned RE_W   = pes_pkg::RE_W_DEF
) (
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              link_quality_i,
    input  wire logic              link_up_i,
    input  wire logic              energy_detect_i,
    input  wire logic              wake_frame_i,
    input  wire logic              esd_event_i,
    input  wire logic              leader_follower_done_i,
    input  wire logic [FC_W-1:0]   false_carrier_counter_i,
    input  wire logic [RE_W-1:0]   receive_error_counter_i,
    output logic                   irq_pin_o,
    output logic                   irq_active_o
);

    // ------------------------------------------------------------------
    // Elaboration checks.
    // ------------------------------------------------------------------
    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("Address bus too narrow for the register map.");
        end
        if (FC_W != 8 || RE_W < 2) begin : g_bad_cnt
            $error("Counter widths not supported.");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] BYTE_STAT =
        ADDR_W'({pes_pkg::IDX_STAT, 2'b00});
    localparam logic [ADDR_W-1:0] BYTE_TEST =
        ADDR_W'({pes_pkg::IDX_TEST, 2'b00});

    logic        hit_stat;
    logic        hit_test;
    logic        req;
    logic        first;
    logic        take;
    logic        wr_stat;
    logic        wr_test;
    logic        rd_stat_take;
    logic [7:0]  evt_w;
    logic [7:0]  clear_mask;
    logic [31:0] read_word;
    logic        active;

    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic [7:0]  snap_ff;
    logic [7:0]  status_ff;
    logic [7:0]  enable_ff;
    logic        polarity_ff;
    logic        test_ff;
    logic        irq_pin_ff;
    logic        irq_active_ff;

    logic [7:0]  nxt_status;

    assign hit_stat = avs_address_i == BYTE_STAT;
    assign hit_test = avs_address_i == BYTE_TEST;

    // ------------------------------------------------------------------
    // Bus handshake: one wait cycle, then the request is taken.
    // ------------------------------------------------------------------
    // The read word is captured in the wait cycle so that it stands at
    // the edge where waitrequest is sampled low.
    assign req          = avs_read_i | avs_write_i;
    assign first        = req & wait_ff;
    assign take         = req & ~wait_ff;
    assign wr_stat      = take & avs_write_i & hit_stat
                          & avs_byteenable_i[0];
    assign wr_test      = take & avs_write_i & hit_test
                          & avs_byteenable_i[0];
    assign rd_stat_take = take & avs_read_i & hit_stat;

    always_comb begin
        read_word = '0;
        if (hit_stat) begin
            read_word[15:8] = status_ff;
            read_word[7:0]  = enable_ff;
        end else if (hit_test) begin
            read_word[15:0] = pes_pkg::RSV_TEST_READ;
            read_word[pes_pkg::POS_POLARITY] = polarity_ff;
            read_word[pes_pkg::POS_TEST]     = test_ff;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~first;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= '0;
        end else if (first && avs_read_i) begin
            rdata_ff <= read_word;
        end
    end

    // Only bits that software has actually seen are cleared later.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap_ff <= '0;
        end else if (first && avs_read_i) begin
            snap_ff <= hit_stat ? status_ff : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Event sources.
    // ------------------------------------------------------------------
    pes_evt_detect #(
        .FC_W (FC_W),
        .RE_W (RE_W)
    ) u_detect (
        .ref_clk_i               (ref_clk_i),
        .resetn_i                (resetn_i),
        .link_quality_i          (link_quality_i),
        .link_up_i               (link_up_i),
        .energy_detect_i         (energy_detect_i),
        .wake_frame_i            (wake_frame_i),
        .esd_event_i             (esd_event_i),
        .leader_follower_done_i  (leader_follower_done_i),
        .false_carrier_counter_i (false_carrier_counter_i),
        .receive_error_counter_i (receive_error_counter_i),
        .evt_o                   (evt_w)
    );

    // ------------------------------------------------------------------
    // Latched status.
    // ------------------------------------------------------------------
    assign clear_mask = rd_stat_take ? snap_ff : 8'h00;
    // Set is applied after the clear, so a fresh event survives.
    assign nxt_status = (status_ff & ~clear_mask) | evt_w;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_ff <= pes_pkg::RST_STATUS;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------------
    // Enables and interrupt control.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_ff <= pes_pkg::RST_ENABLE;
        end else if (wr_stat) begin
            enable_ff <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            polarity_ff <= pes_pkg::RST_POLARITY;
            test_ff     <= pes_pkg::RST_TEST;
        end else if (wr_test) begin
            polarity_ff <= avs_writedata_i[pes_pkg::POS_POLARITY];
            test_ff     <= avs_writedata_i[pes_pkg::POS_TEST];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output.
    // ------------------------------------------------------------------
    // The pin lags the status by one cycle; this keeps it glitch free.
    assign active = (|(status_ff & enable_ff)) | test_ff;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_active_ff <= 1'b0;
            irq_pin_ff    <= pes_pkg::RST_POLARITY;
        end else begin
            irq_active_ff <= active;
            irq_pin_ff    <= active ^ polarity_ff;
        end
    end

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o    = rdata_ff;
    assign irq_pin_o         = irq_pin_ff;
    assign irq_active_o      = irq_active_ff;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_req_first;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence

    sequence s_stat_write;
        wr_stat;
    endsequence

    chk_bus_wait_one:
        assert property (s_req_first |=> !avs_waitrequest_o)
        else $error("Request not answered after one wait cycle.");

    chk_quality_latch:
        assert property (evt_w[pes_pkg::EV_QUALITY]
                         |=> status_ff[pes_pkg::EV_QUALITY])
        else $error("Link quality event not latched.");

    chk_energy_latch:
        assert property (evt_w[pes_pkg::EV_ENERGY]
                         |=> status_ff[pes_pkg::EV_ENERGY])
        else $error("Energy detect event not latched.");

    chk_link_latch:
        assert property ($changed(link_up_i) && $past(resetn_i)
                         && u_detect.primed_ff
                         |=> status_ff[pes_pkg::EV_LINK])
        else $error("Link status change not latched.");

    chk_wake_latch:
        assert property (evt_w[pes_pkg::EV_WAKE] && !rd_stat_take
                         |=> status_ff[pes_pkg::EV_WAKE])
        else $error("Wake frame event not latched.");

    chk_esd_latch:
        assert property (evt_w[pes_pkg::EV_ESD]
                         |=> status_ff[pes_pkg::EV_ESD])
        else $error("Discharge event not latched.");

    chk_training_latch:
        assert property (evt_w[pes_pkg::EV_TRAINING]
                         |=> status_ff[pes_pkg::EV_TRAINING])
        else $error("Training event not latched.");

    chk_counter_latch:
        assert property (evt_w[pes_pkg::EV_FALSE_CAR]
                         |=> status_ff[pes_pkg::EV_FALSE_CAR])
        else $error("False carrier event not latched.");

    chk_rx_err_latch:
        assert property (evt_w[pes_pkg::EV_RX_ERR]
                         |=> status_ff[pes_pkg::EV_RX_ERR])
        else $error("Receive error event not latched.");

    chk_enable_high:
        assert property (s_stat_write
                         |=> enable_ff[7:5] == $past(avs_writedata_i[7:5]))
        else $error("Upper enables not written.");

    chk_enable_mid:
        assert property (s_stat_write
                         |=> enable_ff[4:2] == $past(avs_writedata_i[4:2]))
        else $error("Middle enables not written.");

    chk_enable_low:
        assert property (s_stat_write
                         |=> enable_ff[1:0] == $past(avs_writedata_i[1:0]))
        else $error("Lower enables not written.");

    chk_pin_polarity:
        assert property (##1 irq_pin_o == (irq_active_o ^ $past(polarity_ff)))
        else $error("Interrupt pin level disagrees with polarity.");

    chk_test_force:
        assert property (test_ff |=> irq_active_o
                         && irq_pin_o != $past(polarity_ff))
        else $error("Test bit did not force the interrupt.");

    chk_read_clear:
        assert property (rd_stat_take
                         |=> (status_ff & $past(snap_ff & ~evt_w)) == 8'h00)
        else $error("Read did not clear returned status bits.");

    chk_irq_active:
        assert property ((|(status_ff & enable_ff)) |=> irq_active_o)
        else $error("Enabled pending event raised no interrupt.");

    chk_irq_quiet:
        assert property (!test_ff && (status_ff & enable_ff) == 8'h00
                         |=> !irq_active_o)
        else $error("Interrupt raised with nothing pending.");

    chk_set_wins:
        assert property (rd_stat_take && (|evt_w)
                         |=> (status_ff & $past(evt_w)) == $past(evt_w))
        else $error("Fresh event lost to a status read.");

    // A status bit may only rise through an event, never through a write.
    chk_no_false_set:
        assert property (##1 (status_ff & ~$past(status_ff | evt_w)) == 8'h00)
        else $error("Status bit rose without an event.");

    chk_wait_idle:
        assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("Waitrequest low without a request.");

    sequence s_stat_read_first;
        s_req_first ##0 (avs_read_i && hit_stat);
    endsequence

    chk_read_data:
        assert property (s_stat_read_first
                         |=> avs_readdata_o[15:0]
                             == {$past(status_ff), $past(enable_ff)})
        else $error("Read data does not show the register contents.");

endmodule

`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;

    // ------------------------------------------------------------------
    // Stimulus and design hookup.
    // ------------------------------------------------------------------
    localparam logic [7:0] A_STAT = {pes_pkg::IDX_STAT, 2'b00};
    localparam logic [7:0] A_TEST = {pes_pkg::IDX_TEST, 2'b00};
    localparam logic [7:0] A_NONE = 8'h80;

    logic        ref_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        link_quality_i = 1'b0;
    logic        link_up_i = 1'b0;
    logic        energy_detect_i = 1'b0;
    logic        wake_frame_i = 1'b0;
    logic        esd_event_i = 1'b0;
    logic        leader_follower_done_i = 1'b0;
    logic [7:0]  false_carrier_counter_i = 8'h00;
    logic [15:0] receive_error_counter_i = 16'h0000;
    logic        irq_pin_o;
    logic        irq_active_o;
    int          bad_count = 0;
    int          checks_done = 0;
    logic [31:0] d;

    always #2 ref_clk_i = ~ref_clk_i;

    pes_event_status_one dut (
        .ref_clk_i               (ref_clk_i),
        .resetn_i                (resetn_i),
        .avs_address_i           (avs_address_i),
        .avs_read_i              (avs_read_i),
        .avs_write_i             (avs_write_i),
        .avs_writedata_i         (avs_writedata_i),
        .avs_byteenable_i        (avs_byteenable_i),
        .avs_readdata_o          (avs_readdata_o),
        .avs_waitrequest_o       (avs_waitrequest_o),
        .link_quality_i          (link_quality_i),
        .link_up_i               (link_up_i),
        .energy_detect_i         (energy_detect_i),
        .wake_frame_i            (wake_frame_i),
        .esd_event_i             (esd_event_i),
        .leader_follower_done_i  (leader_follower_done_i),
        .false_carrier_counter_i (false_carrier_counter_i),
        .receive_error_counter_i (receive_error_counter_i),
        .irq_pin_o               (irq_pin_o),
        .irq_active_o            (irq_active_o)
    );

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The request is held until waitrequest is sampled low at an edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        avs_address_i    <= a;
        avs_writedata_i  <= wd;
        avs_byteenable_i <= be;
        avs_read_i       <= ~wr;
        avs_write_i      <= wr;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            chk("waitrequest", 32'h0, 32'h1);
        end
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, 4'hF, r);
        chk("readdata", e, r);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        bus(1'b1, a, v, 4'hF, r);
    endtask

    task automatic pins(input logic act, input logic pin);
        repeat (3) @(posedge ref_clk_i);
        chk("irq_active_o", {31'h0, act}, {31'h0, irq_active_o});
        chk("irq_pin_o", {31'h0, pin}, {31'h0, irq_pin_o});
    endtask

    function automatic logic [31:0] tst(input logic pol, input logic t);
        return {16'h0, pes_pkg::RSV_TEST_READ} | {28'h0, pol, t, 2'b00};
    endfunction

    task automatic ev_set(input int k, input logic v);
        case (k)
            0: wake_frame_i <= v;
            1: esd_event_i <= v;
            default: leader_follower_done_i <= v;
        endcase
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(A_STAT, 32'h0000_0000);
        rd_chk(A_TEST, tst(1'b1, 1'b0));
        rd_chk(A_NONE, 32'h0000_0000);
        pins(1'b0, 1'b1);
    endtask

    task automatic t_enables();
        wr(A_STAT, 32'hFFFF_FFFF);
        rd_chk(A_STAT, 32'h0000_00FF);
        bus(1'b1, A_STAT, 32'h0, 4'h0, d);
        rd_chk(A_STAT, 32'h0000_00FF);
        wr(A_NONE, 32'h0);
        rd_chk(A_STAT, 32'h0000_00FF);
        wr(A_STAT, 32'h0000_0000);
        rd_chk(A_STAT, 32'h0000_0000);
    endtask

    // Pulse sources: a rising edge latches, a read returns and clears.
    task automatic t_pulses();
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk_i);
            ev_set(k, 1'b1);
            repeat (3) @(posedge ref_clk_i);
            ev_set(k, 1'b0);
            rd_chk(A_STAT, 32'h1 << (12 - k));
            rd_chk(A_STAT, 32'h0);
        end
    endtask

    task automatic t_levels();
        energy_detect_i <= 1'b1;
        rd_chk(A_STAT, 32'h0000_4000);
        energy_detect_i <= 1'b0;
        rd_chk(A_STAT, 32'h0000_4000);
        link_quality_i <= 1'b1;
        rd_chk(A_STAT, 32'h0000_0000);
        link_up_i <= 1'b1;
        rd_chk(A_STAT, 32'h0000_2000);
        link_quality_i <= 1'b0;
        rd_chk(A_STAT, 32'h0000_8000);
        link_up_i <= 1'b0;
        rd_chk(A_STAT, 32'h0000_2000);
    endtask

    // The false carrier threshold is crossed only by a step past 0x7F, the receive error one by a step past 0x7FFF.
    task automatic t_counters();
        false_carrier_counter_i <= pes_pkg::FC_HALF;
        rd_chk(A_STAT, 32'h0000_0000);
        false_carrier_counter_i <= 8'h80;
        rd_chk(A_STAT, 32'h0000_0200);
        false_carrier_counter_i <= 8'hFF;
        rd_chk(A_STAT, 32'h0000_0000);
        receive_error_counter_i <= 16'h8000;
        rd_chk(A_STAT, 32'h0000_0100);
    endtask

    task automatic t_irq();
        wr(A_STAT, 32'h0000_0008);
        wake_frame_i <= 1'b1;
        pins(1'b0, 1'b1);
        wake_frame_i <= 1'b0;
        rd_chk(A_STAT, 32'h0000_1008);
        esd_event_i <= 1'b1;
        pins(1'b1, 1'b0);
        esd_event_i <= 1'b0;
        rd_chk(A_STAT, 32'h0000_0808);
        pins(1'b0, 1'b1);
        wr(A_STAT, 32'h0000_0000);
    endtask

    task automatic t_polarity();
        wr(A_TEST, 32'h0000_0000);
        rd_chk(A_TEST, tst(1'b0, 1'b0));
        pins(1'b0, 1'b0);
        wr(A_TEST, 32'h0000_0004);
        pins(1'b1, 1'b1);
        wr(A_TEST, 32'h0000_000C);
        rd_chk(A_TEST, tst(1'b1, 1'b1));
        pins(1'b1, 1'b0);
        wr(A_TEST, 32'h0000_0008);
        pins(1'b0, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog.
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_reset();
        t_enables();
        t_pulses();
        t_levels();
        t_counters();
        t_irq();
        t_polarity();
        summarize();
    end

    // The full run needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        bad_count++;
        summarize();
    end

endmodule

`default_nettype wire
